// ### src/sac_ctrl.v
// Purpose: Digital control of an 8-bit successive-approximation converter
// Assumes: Comparator and DAC are an analog macro clocked by CLK
// Notes:   Select and serial clock are pins and are synchronised first
//
// How it works
// - Clamp corrected codes at 00 for low inputs; top inputs give FF less the stored offset.
// - Result is unsigned straight binary, one LSB is reference over 256.
// - A frame runs from select falling to select rising; one sample each, except the power-up frame.
// - Sample at select fall; CLK paces conversion, serial clock paces shifting.
// - Output frame is ten bits: two zeros then eight result bits.
// - First zero at select fall, later bits on each clock falling edge.
// - After ten clock cycles the data output stays low.
// - Select rising ends the frame and releases the data output.
// - First frame after power-up calibrates and keeps data output low.
// - Power-up calibration commits only after 16 clock falls, else kept.
// - Power-up calibration lasts at least 15 serial clock periods.
// - Offset store is zero at power-up; only power cycling clears it.
// - Offset store has no read or write path from the serial side.
// - Analog inputs are disconnected while calibration runs.
// - Every later result is corrected by the stored offset.
// - Normal frame: data in first 10 clocks, calibrate edges 17 to 32.
// - Normal frame with fewer than 32 clock falls keeps the offset.
`default_nettype none
`include "sac_regs.vh"

module sac_ctrl (
  input  wire                  CLK,
  input  wire                  NRST,
  input  wire                  CS_N,
  input  wire                  SCLK,
  input  wire                  COMP,
  output wire                  SDO_OUT,
  output wire                  SDO_OE,
  output wire                  TRACK,
  output wire                  INPUT_CONNECT,
  output wire [`SAC_RES_W-1:0] DAC_CODE,
  output wire                  CAL_BUSY
);

  // Pin synchronisers; the second stage and its delayed copy are read by logic
  reg cs_s1_reg;
  reg cs_s2_reg;
  reg cs_prev_reg;
  reg sclk_s1_reg;
  reg sclk_s2_reg;
  reg sclk_prev_reg;

  always @(posedge CLK) begin
    if (!NRST) begin
      cs_s1_reg     <= 1'b1;
      cs_s2_reg     <= 1'b1;
      cs_prev_reg   <= 1'b1;
      sclk_s1_reg   <= 1'b0;
      sclk_s2_reg   <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      cs_s1_reg     <= CS_N;
      cs_s2_reg     <= cs_s1_reg;
      cs_prev_reg   <= cs_s2_reg;
      sclk_s1_reg   <= SCLK;
      sclk_s2_reg   <= sclk_s1_reg;
      sclk_prev_reg <= sclk_s2_reg;
    end
  end

  wire frame_start = cs_prev_reg & ~cs_s2_reg;
  wire frame_end   = ~cs_prev_reg & cs_s2_reg;
  wire in_frame    = ~cs_s2_reg;
  wire sclk_fall   = in_frame & sclk_prev_reg & ~sclk_s2_reg;

  // Falling-edge count, saturating so long frames do not wrap
  reg [`SAC_CNT_W-1:0] edge_cnt_reg;
  reg [`SAC_CNT_W-1:0] edge_cnt_next;

  always @* begin
    edge_cnt_next = edge_cnt_reg;
    if (frame_start) begin
      edge_cnt_next = `SAC_EDGE_NONE;
    end else if (sclk_fall && edge_cnt_reg != `SAC_EDGE_MAX) begin
      edge_cnt_next = edge_cnt_reg + 6'h01;
    end
  end

  wire new_edge = sclk_fall && edge_cnt_reg != `SAC_EDGE_MAX;

  // power-up flag; power-up is the only reset
  reg first_frame_reg;
  reg first_frame_next;

  always @* begin
    first_frame_next = first_frame_reg;
    if (frame_end) begin
      first_frame_next = 1'b0;
    end
  end

  // Calibration control
  reg cal_active_reg;
  reg cal_active_next;
  reg cal_ready_reg;
  reg cal_ready_next;
  reg [`SAC_RES_W-1:0] cal_code_reg;
  reg [`SAC_RES_W-1:0] cal_code_next;
  reg [`SAC_RES_W-1:0] offset_correction_store_reg;
  reg [`SAC_RES_W-1:0] offset_correction_store_next;

  // Successive approximation engine shared by samples and calibration
  reg [1:0]            sar_state_reg;
  reg [1:0]            sar_state_next;
  reg [`SAC_RES_W-1:0] sar_code_reg;
  reg [`SAC_RES_W-1:0] sar_code_next;
  reg [`SAC_RES_W-1:0] sar_mask_reg;
  reg [`SAC_RES_W-1:0] sar_mask_next;
  reg                  sar_is_cal_reg;
  reg                  sar_is_cal_next;
  reg                  track_reg;
  reg                  track_next;

  localparam [1:0] ST_IDLE = `SAC_ST_IDLE;
  localparam [1:0] ST_STEP = `SAC_ST_STEP;
  localparam [1:0] ST_DONE = `SAC_ST_DONE;

  wire start_cal_normal = in_frame && !first_frame_reg && new_edge &&
                          edge_cnt_next == `SAC_EDGE_CAL_START;
  wire start_cal_pwrup  = frame_start && first_frame_reg;
  wire start_sample     = frame_start && !first_frame_reg;

  // Offset correction with clamping to the code range
  reg [`SAC_RES_W-1:0] corrected;

  always @* begin
    // offset removed before shifting; clamped at code 00
    if (sar_code_reg > offset_correction_store_reg) begin
      corrected = sar_code_reg - offset_correction_store_reg;
    end else begin
      corrected = `SAC_CODE_ZERO;
    end
  end

  wire buf_in_ready;
  wire buf_in_valid = (sar_state_reg == ST_DONE) && !sar_is_cal_reg;

  always @* begin
    sar_state_next  = sar_state_reg;
    sar_code_next   = sar_code_reg;
    sar_mask_next   = sar_mask_reg;
    sar_is_cal_next = sar_is_cal_reg;
    track_next      = track_reg;
    cal_code_next   = cal_code_reg;
    cal_ready_next  = cal_ready_reg;
    case (sar_state_reg)
      ST_IDLE: begin
        if (start_sample || start_cal_pwrup || start_cal_normal) begin
          // hold the input from the select fall onward, or from edge 17 for a normal-frame calibration
          track_next      = 1'b0;
          sar_state_next  = ST_STEP;
          sar_code_next   = `SAC_CODE_MID;
          sar_mask_next   = `SAC_MASK_MSB;
          sar_is_cal_next = ~start_sample;
          cal_ready_next  = 1'b0;
        end
      end
      ST_STEP: begin
        // binary search, keep the trial bit when input is above
        if (!COMP) begin
          sar_code_next = sar_code_reg & ~sar_mask_reg;
        end
        if (sar_mask_reg == `SAC_MASK_LSB) begin
          sar_state_next = ST_DONE;
        end else begin
          sar_mask_next = sar_mask_reg >> 1;
          sar_code_next = (COMP ? sar_code_reg
                                : (sar_code_reg & ~sar_mask_reg))
                          | (sar_mask_reg >> 1);
        end
      end
      ST_DONE: begin
        if (sar_is_cal_reg) begin
          cal_code_next  = sar_code_reg;
          cal_ready_next = 1'b1;
          sar_state_next = ST_IDLE;
          // offset code taken; inputs stay cut while cal_active_reg is set, tracking resumes at frame end
          sar_is_cal_next = 1'b0;
        end else if (buf_in_ready) begin
          // A full buffer stalls here until the shifter drains a word
          sar_state_next = ST_IDLE;
          track_next     = 1'b1;
        end
      end
      default: begin
        sar_state_next = ST_IDLE;
      end
    endcase
    if (frame_end) begin
      // Reconnect for acquisition; the host times it
      track_next = 1'b1;
    end
  end

  always @* begin
    cal_active_next = cal_active_reg;
    offset_correction_store_next = offset_correction_store_reg;
    if (start_cal_pwrup || start_cal_normal) begin
      cal_active_next = 1'b1;
    end
    // power-up commit at edge 16; spans 15 periods at least
    if (first_frame_reg && cal_active_reg && new_edge &&
        edge_cnt_next == `SAC_EDGE_PWRUP_CAL) begin
      cal_active_next = 1'b0;
      if (cal_ready_next) begin
        offset_correction_store_next = cal_code_next;
      end
    end
    // normal calibration ends on edge 32
    if (!first_frame_reg && cal_active_reg && new_edge &&
        edge_cnt_next == `SAC_EDGE_CAL_END) begin
      cal_active_next = 1'b0;
      if (cal_ready_next) begin
        offset_correction_store_next = cal_code_next;
      end
    end
    // short frame abandons the calibration, store kept
    if (frame_end) begin
      cal_active_next = 1'b0;
    end
  end

  // Result buffer between conversion and shifter
  wire                  buf_out_valid;
  wire [`SAC_RES_W-1:0] buf_out_data;
  wire                  load_edge = in_frame && new_edge &&
                                    edge_cnt_next == `SAC_EDGE_RES_FIRST;
  // A word left unread by a frame cut before edge 2 is dropped at its end
  wire                  buf_pop   = (load_edge || frame_end) &&
                                    !first_frame_reg;

  sac_buf2 #(
    .WIDTH (`SAC_RES_W)
  ) u_buf (
    .clk       (CLK),
    .nrst      (NRST),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (corrected),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  // Serial output shifter
  reg [`SAC_RES_W-1:0] shift_reg;
  reg [`SAC_RES_W-1:0] shift_next;
  reg                  sdo_reg;
  reg                  sdo_next;
  reg                  sdo_oe_reg;
  reg                  sdo_oe_next;

  always @* begin
    shift_next  = shift_reg;
    sdo_next    = sdo_reg;
    sdo_oe_next = sdo_oe_reg;
    if (frame_start) begin
      // first zero launched at the select fall
      sdo_oe_next = 1'b1;
      sdo_next    = 1'b0;
    end else if (frame_end) begin
      sdo_oe_next = 1'b0;
      sdo_next    = 1'b0;
    end else if (new_edge) begin
      if (first_frame_reg) begin
        sdo_next = 1'b0;
      end else if (edge_cnt_next == `SAC_EDGE_RES_FIRST) begin
        // most significant bit first; after two zeros
        if (buf_out_valid) begin
          sdo_next   = buf_out_data[`SAC_RES_W-1];
          shift_next = buf_out_data << 1;
        end else begin
          sdo_next   = 1'b0;
          shift_next = `SAC_CODE_ZERO;
        end
      end else if (edge_cnt_next > `SAC_EDGE_RES_FIRST &&
                   edge_cnt_next <= `SAC_EDGE_RES_LAST) begin
        sdo_next   = shift_reg[`SAC_RES_W-1];
        shift_next = shift_reg << 1;
      end else begin
        // second zero, and low from edge 10 onward
        sdo_next = 1'b0;
      end
    end
  end

  always @(posedge CLK) begin
    if (!NRST) begin
      edge_cnt_reg   <= `SAC_EDGE_NONE;
      first_frame_reg <= 1'b1;
      cal_active_reg <= 1'b0;
      cal_ready_reg  <= 1'b0;
      cal_code_reg   <= `SAC_CODE_ZERO;
      offset_correction_store_reg <= `SAC_CODE_ZERO;
      sar_state_reg  <= ST_IDLE;
      sar_code_reg   <= `SAC_CODE_ZERO;
      sar_mask_reg   <= `SAC_CODE_ZERO;
      sar_is_cal_reg <= 1'b0;
      track_reg      <= 1'b1;
      shift_reg      <= `SAC_CODE_ZERO;
      sdo_reg        <= 1'b0;
      sdo_oe_reg     <= 1'b0;
    end else begin
      edge_cnt_reg   <= edge_cnt_next;
      first_frame_reg <= first_frame_next;
      cal_active_reg <= cal_active_next;
      cal_ready_reg  <= cal_ready_next;
      cal_code_reg   <= cal_code_next;
      offset_correction_store_reg <= offset_correction_store_next;
      sar_state_reg  <= sar_state_next;
      sar_code_reg   <= sar_code_next;
      sar_mask_reg   <= sar_mask_next;
      sar_is_cal_reg <= sar_is_cal_next;
      track_reg      <= track_next;
      shift_reg      <= shift_next;
      sdo_reg        <= sdo_next;
      sdo_oe_reg     <= sdo_oe_next;
    end
  end

  // Next trial code is registered to the DAC every cycle and holds after conversion
  reg [`SAC_RES_W-1:0] dac_reg;

  always @(posedge CLK) begin
    if (!NRST) begin
      dac_reg <= `SAC_CODE_ZERO;
    end else begin
      dac_reg <= sar_code_next;
    end
  end

  // the store reaches a port only through the corrected result on SDO_OUT
  assign SDO_OUT  = sdo_reg;
  assign SDO_OE   = sdo_oe_reg;
  assign TRACK    = track_reg;
  assign INPUT_CONNECT = ~cal_active_reg & ~sar_is_cal_reg;
  assign DAC_CODE = dac_reg;
  assign CAL_BUSY = cal_active_reg;

endmodule

`default_nettype wire

// ### src/sac_regs.vh
// Purpose: Shared constants of the converter control block
// Assumes: 200 MHz system clock, host drives select and serial clock
// Notes:   Edge counts are serial-clock falling edges inside one frame
`ifndef SAC_REGS_VH
`define SAC_REGS_VH

// Data path widths
`define SAC_RES_W            8
`define SAC_CNT_W            6
`define SAC_FRAME_BITS       10

// Codes of the transfer characteristic
`define SAC_CODE_ZERO        8'h00
`define SAC_CODE_MID         8'h80
`define SAC_CODE_FULL        8'hFF
`define SAC_MASK_MSB         8'h80
`define SAC_MASK_LSB         8'h01

// Edge numbers within a frame
`define SAC_EDGE_NONE        6'h00
`define SAC_EDGE_RES_FIRST   6'h02
`define SAC_EDGE_RES_LAST    6'h09
`define SAC_EDGE_DATA_END    6'h0A
`define SAC_EDGE_PWRUP_CAL   6'h10
`define SAC_EDGE_CAL_START   6'h11
`define SAC_EDGE_CAL_END     6'h20
`define SAC_EDGE_MAX         6'h3F

// Host timing, in ns, kept for reference by the bench
`define SAC_T_SETUP_NS       15
`define SAC_T_DESELECT_NS    10
`define SAC_ACQUISITION_INTERVAL_NS         275
`define SAC_CLK_PERIOD_NS    5

// Successive approximation states
`define SAC_ST_IDLE          2'h0
`define SAC_ST_STEP          2'h1
`define SAC_ST_DONE          2'h2

`endif

// ### src/sac_buf2.v
// Purpose: Two-entry word buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Full and empty are exact; a push and pop may share a cycle
`default_nettype none

module sac_buf2 #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:1];
  reg             wr_ptr_reg;
  reg             rd_ptr_reg;
  reg [1:0]       count_reg;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ### bench/sac_chk_assertions.sv
// Purpose: Port checks for the converter control
// Assumes: Select and serial clock change just after CLK edges
// Notes:   Serial clock falls are counted at the pins
`default_nettype none
`include "sac_regs.vh"

module sac_chk (
  input wire logic                  CLK,
  input wire logic                  NRST,
  input wire logic                  CS_N,
  input wire logic                  SCLK,
  input wire logic                  COMP,
  input wire logic                  SDO_OUT,
  input wire logic                  SDO_OE,
  input wire logic                  TRACK,
  input wire logic                  INPUT_CONNECT,
  input wire logic [`SAC_RES_W-1:0] DAC_CODE,
  input wire logic                  CAL_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_reg;
  logic       sclk_reg;
  logic       cs_reg;
  logic       pu_reg;

  // Pin count leads the design's synchronised count by a few cycles
  always_ff @(posedge CLK) begin
    sclk_reg <= SCLK;
    cs_reg   <= CS_N;
    if (!NRST || CS_N)
      cnt_reg <= 6'h00;
    else if (sclk_reg && !SCLK && cnt_reg != 6'h3F)
      cnt_reg <= cnt_reg + 6'h01;
    if (!NRST)
      pu_reg <= 1'b1;
    else if (CS_N && !cs_reg)
      pu_reg <= 1'b0;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence frame_open;
    $fell(CS_N);
  endsequence
  sequence sampled;
    TRACK ##[2:5] !TRACK;
  endsequence

  oe_release_a: assert property (CS_N [*6] |-> !SDO_OE)
    else $error("data output driven while deselected");
  first_zero_a: assert property (
    frame_open |-> ##[2:6] (SDO_OE && !SDO_OUT))
    else $error("frame did not open with a driven zero");
  sample_hold_a: assert property (frame_open |-> sampled)
    else $error("no sample taken at select fall");
  cal_cut_a: assert property (CAL_BUSY |-> !INPUT_CONNECT)
    else $error("inputs connected during calibration");
  input_reconnect_a: assert property (!INPUT_CONNECT |-> CAL_BUSY)
    else $error("inputs cut outside calibration");
  tail_low_a: assert property (cnt_reg > 6'h0A |-> !SDO_OUT)
    else $error("data high after ten clocks");
  pu_quiet_a: assert property (pu_reg && !CS_N |-> !SDO_OUT)
    else $error("data high in power-up frame");
  pu_cal_a: assert property (
    pu_reg && cnt_reg inside {[6'h01:6'h0F]} |-> CAL_BUSY)
    else $error("power-up calibration ended early");
  norm_wait_a: assert property (
    !pu_reg && cnt_reg inside {[6'h01:6'h10]} |-> !CAL_BUSY)
    else $error("calibration before edge 17");
  norm_cal_a: assert property (
    !pu_reg && cnt_reg inside {[6'h12:6'h1F]} |-> CAL_BUSY)
    else $error("calibration window not open");
endmodule

bind sac_ctrl sac_chk u_chk (.CLK(CLK), .NRST(NRST), .CS_N(CS_N),
  .SCLK(SCLK), .COMP(COMP), .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE),
  .TRACK(TRACK), .INPUT_CONNECT(INPUT_CONNECT), .DAC_CODE(DAC_CODE),
  .CAL_BUSY(CAL_BUSY));
`default_nettype wire

// ### bench/sac_host.sv
// Purpose: Host serial master and analog comparator model
// Assumes: SAR keeps a trial bit when the comparator is high
// Notes:   Serial clock idles high and stands still between frames
`default_nettype none

module sac_host (
  input  wire logic       clk,
  input  wire logic [7:0] dac_code,
  input  wire logic       input_connect,
  input  wire logic       sdo_out,
  input  wire logic       sdo_oe,
  output var  logic       cs_n,
  output var  logic       sclk,
  output wire logic       comp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] vin;
  logic [7:0] off;
  logic       last;
  wire  logic line;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    vin  = 8'h00;
    off  = 8'h00;
    last = 1'b0;
  end
  // Half an LSB above vin plus offset; only offset when cut off
  assign comp = {1'b0, input_connect ? vin : 8'h00, 1'b1} + {off, 1'b0}
                > {1'b0, dac_code, 1'b0};
  // A released line shows no stale value
  assign line = sdo_oe ? sdo_out : !last;

  // one select low period, 90 ns clock
  task automatic frame(input int n, output logic [9:0] w,
                       output logic tail);
    w = 10'h000;
    tail = 1'b0;
    @(posedge clk) cs_n <= 1'b0;
    repeat (6) @(posedge clk);
    w[9] = line;
    last = line;
    for (int i = 1; i <= n; i++) begin
      sclk <= 1'b0;
      repeat (9) @(posedge clk);
      sclk <= 1'b1;
      if (i < 10) w[9-i] = line;
      else tail = tail | line;
      last = line;
      repeat (9) @(posedge clk);
    end
    cs_n <= 1'b1;
    repeat (60) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench of the converter control
// Assumes: Host model frames every sample
// Notes:   Offset seen by the comparator is set per test
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  wire  logic cs_n, sclk, comp, sdo, oe, trk, conn, busy;
  wire  logic [7:0] dac;
  int         n_errors = 0;
  int         total_checks = 0;
  int         seed = 32'hdbbd90cd;
  int         n;
  logic [9:0] w;
  logic       t;
  logic [7:0] sto;

  always #2.5 clk = ~clk;

  sac_ctrl dut (.CLK(clk), .NRST(nrst), .CS_N(cs_n), .SCLK(sclk),
    .COMP(comp), .SDO_OUT(sdo), .SDO_OE(oe), .TRACK(trk),
    .INPUT_CONNECT(conn), .DAC_CODE(dac), .CAL_BUSY(busy));
  sac_host host (.clk(clk), .dac_code(dac), .input_connect(conn),
    .sdo_out(sdo), .sdo_oe(oe), .cs_n(cs_n), .sclk(sclk), .comp(comp));

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Raw code saturates at full scale, correction clamps at zero
  function automatic logic [9:0] word(input logic [7:0] v, o, s);
    logic [8:0] raw;
    raw = v + o;
    if (raw > 9'h0FF) raw = 9'h0FF;
    word = (raw[7:0] > s) ? {2'b00, raw[7:0] - s} : 10'h000;
  endfunction

  task automatic conv(input logic [7:0] vi, input int ne);
    host.vin <= vi;
    host.frame(ne, w, t);
    check({2'h0, w}, {2'h0, word(vi, host.off, sto)});
    check({11'h000, t}, 12'h000);
    $display("frame of %0d edges, word %h", ne, w);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk);
    check({oe, trk, busy, conn, dac}, 12'h500);
    nrst <= 1'b1;
    host.off <= 8'h05;
    sto = 8'h00;
    host.frame(8, w, t);
    check({2'h0, w}, 12'h000);
    conv(8'h40, 10);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    host.frame(16, w, t);
    check({2'h0, w}, 12'h000);
    sto = 8'h05;
    conv(8'h00, 10);
    conv(8'h80, 12);
    conv(8'hFA, 10);
    host.off <= 8'h02;
    conv(8'h01, 10);
    host.off <= 8'h09;
    conv(8'h30, 31);
    conv(8'h30, 32);
    sto = 8'h09;
    conv(8'h30, 10);
    for (int k = 0; k < 20; k++) begin
      host.off <= 8'($random(seed)) & 8'h0F;
      n = (k % 4 == 3) ? 32 : 10 + k % 3;
      conv(8'($random(seed)), n);
      if (n == 32) sto = host.off;
    end
    host.off <= 8'h0A;
    conv(8'h20, 32);
    sto = 8'h0A;
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    host.frame(15, w, t);
    check({2'h0, w}, 12'h000);
    sto = 8'h00;
    conv(8'h50, 10);
    results();
  end
endmodule
`default_nettype wire
